// [bgdbg_defines.svh]
// Constants for the background debug command port
`ifndef BGDBG_DEFINES_SVH
`define BGDBG_DEFINES_SVH
// ----------------------------------------
// Page index register layout
// ----------------------------------------
`define BGDBG_GAE_BIT 7
`define BGDBG_PAGE_MSB 6
`define BGDBG_PAGE_LSB 0
`define BGDBG_PAGE_RESET 8'h00
// ----------------------------------------
// Family identifier location and value
// ----------------------------------------
`define BGDBG_FAMILY_ADDR 23'h7fff0f
`define BGDBG_FAMILY_ID 8'h5a
// ----------------------------------------
// Command codes
// ----------------------------------------
`define BGDBG_CMD_NOP 4'h0
`define BGDBG_CMD_BACKGROUND 4'h1
`define BGDBG_CMD_READ_MEM 4'h2
`define BGDBG_CMD_WRITE_MEM 4'h3
`define BGDBG_CMD_READ_PORT 4'h4
`define BGDBG_CMD_WRITE_PORT 4'h5
`define BGDBG_CMD_READ_CPU 4'h8
`define BGDBG_CMD_WRITE_CPU 4'h9
`define BGDBG_CMD_GO 4'ha
`define BGDBG_CMD_READ_FW_MEM 4'hb
`define BGDBG_CMD_WRITE_FW_MEM 4'hc
// ----------------------------------------
// Serial framing
// ----------------------------------------
`define BGDBG_CMD_BITS 44
`define BGDBG_RSP_BITS 16
`define BGDBG_BIT_CYCLES 8'd16
`endif

// [bgdbg_host.sv]
// Debug host model driving the single-wire command link
module bgdbg_host (
    input wire logic clk_sys_in, // System clock
    input wire logic line_in, // Resolved wire level
    input wire logic dev_oe_in, // Device drive enable
    output logic pull_low_out // Host pulls wire low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pull_low_out = 1'b0;
    // Short low sends a one, long low a zero, msb first
    task automatic send(input logic [43:0] f);
        for (int i = 43; i >= 0; i--) begin
            @(posedge clk_sys_in) #1 pull_low_out = 1'b1;
            repeat (f[i] ? 2 : 12) @(posedge clk_sys_in);
            #1 pull_low_out = 1'b0;
            repeat (f[i] ? 13 : 3) @(posedge clk_sys_in);
        end
    endtask
    // Samples ten clocks into each answer cell
    task automatic recv(output logic [15:0] w);
        @(posedge dev_oe_in);
        for (int i = 15; i >= 0; i--) begin
            repeat (10) @(posedge clk_sys_in);
            w[i] = line_in;
            repeat (6) @(posedge clk_sys_in);
        end
    endtask
    // Sends a read and collects its answer
    task automatic xfer(input logic [43:0] f, output logic [15:0] w);
        fork
            send(f);
            recv(w);
        join
    endtask
endmodule

// [bgdbg_pkg.sv]
// Types shared by the background debug command port
package bgdbg_pkg;
    typedef enum logic [2:0] {
        BGDBG_CPU_A, BGDBG_CPU_X, BGDBG_CPU_Y, BGDBG_CPU_SP, BGDBG_CPU_PC
    } bgdbg_cpu_reg_t;
    typedef enum {
        BGDBG_IDLE, BGDBG_RECV, BGDBG_EXEC, BGDBG_WAIT, BGDBG_SEND
    } bgdbg_state_t;
endpackage

// [bgdbg_port.sv]
// Background debug command port: decode, security and page addressing
`include "bgdbg_defines.svh"
// How it works
// [RULE1] Enable bit selects global page addressing
// [RULE2] Port register commands never go global
// [RULE3] Page field gives address bits 22-16
// [RULE4] Page register reachable only when unsecured
// [RULE5] Read-only family identifier at fixed address
// [RULE6] Commands arrive over one serial wire
// [RULE7] Hardware commands: memory access, enter debug
// [RULE8] Memory bus reaches all CPU space
// [RULE9] Firmware commands: CPU registers, exit debug
// [RULE10] Hardware commands refused while secured
// [RULE11] Firmware commands need unsecured active debug
// [RULE12] Global address is page over address
module bgdbg_port #(
    parameter int ADDR_W = 23 // Global address width
) (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic secure_in, // Device is secured
    input wire logic bkgd_in, // Debug wire input level
    output logic bkgd_out, // Debug wire drive level
    output logic bkgd_oe_out, // Debug wire drive enable
    output logic mem_req_out, // Memory request level
    output logic mem_we_out, // Memory write
    output logic mem_global_out, // Access is global
    output logic [ADDR_W-1:0] mem_addr_out, // Memory address
    output logic [15:0] mem_wdata_out, // Memory write data
    input wire logic mem_ack_in, // Memory access done
    input wire logic [15:0] mem_rdata_in, // Memory read data
    output logic cpu_halt_out, // Active background debug mode
    output logic cpu_req_out, // CPU register write pulse
    output logic cpu_we_out, // CPU register write
    output logic [2:0] cpu_sel_out, // CPU register select
    output logic [15:0] cpu_wdata_out, // CPU register write data
    input wire logic [15:0] cpu_rdata_in, // CPU register read data
    output logic refused_out // Pulse: last command refused
);
    logic [7:0] page_r;
    logic [7:0] page_nxt;
    logic active_r;
    logic [15:0] rsp_r;
    logic send_r;
    logic frame_valid;
    logic [43:0] frame;
    logic ser_busy;
    logic ser_out;
    logic ser_oe;
    bgdbg_pkg::bgdbg_state_t state_r;
    bgdbg_pkg::bgdbg_state_t state_nxt;
    logic [15:0] rsp_nxt;
    // ----------------------------------------
    // Serial link
    // ----------------------------------------
    // Frame: cmd[43:40] sel[38:36] addr[31:16] data[15:0]
    bgdbg_serial bgdbg_serial_inst (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .wire_in(bkgd_in),
        .send_in(send_r),
        .send_data_in(rsp_r),
        .wire_out(ser_out),
        .wire_oe_out(ser_oe),
        .frame_valid_out(frame_valid),
        .frame_out(frame),
        .busy_out(ser_busy)
    ); // [RULE6]
    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire [3:0] cmd = frame[43:40];
    wire [15:0] cmd_addr = frame[31:16];
    wire [15:0] cmd_data = frame[15:0];
    wire is_hw_mem = (cmd == `BGDBG_CMD_READ_MEM) || (cmd == `BGDBG_CMD_WRITE_MEM);
    wire is_fw_mem = (cmd == `BGDBG_CMD_READ_FW_MEM) || (cmd == `BGDBG_CMD_WRITE_FW_MEM);
    wire is_port = (cmd == `BGDBG_CMD_READ_PORT) || (cmd == `BGDBG_CMD_WRITE_PORT);
    wire is_hw = is_hw_mem || is_port || (cmd == `BGDBG_CMD_BACKGROUND);
    wire is_fw = is_fw_mem || (cmd == `BGDBG_CMD_READ_CPU) || (cmd == `BGDBG_CMD_WRITE_CPU)
        || (cmd == `BGDBG_CMD_GO);
    wire hw_ok = is_hw && !secure_in; // [RULE10]
    wire fw_ok = is_fw && !secure_in && active_r; // [RULE11]
    wire go_global = page_r[`BGDBG_GAE_BIT] && (is_hw_mem || is_fw_mem); // [RULE1] [RULE2]
    wire [ADDR_W-1:0] glob_addr = ADDR_W'({page_r[`BGDBG_PAGE_MSB:`BGDBG_PAGE_LSB],
        cmd_addr}); // [RULE3] [RULE12]
    wire [ADDR_W-1:0] local_addr = ADDR_W'(cmd_addr);
    wire id_hit = go_global && (glob_addr == ADDR_W'(`BGDBG_FAMILY_ADDR)) &&
        ((cmd == `BGDBG_CMD_READ_MEM) || (cmd == `BGDBG_CMD_READ_FW_MEM)); // [RULE5]
    wire is_wr = (cmd == `BGDBG_CMD_WRITE_MEM) || (cmd == `BGDBG_CMD_WRITE_FW_MEM);
    // Page register write, only via port command when unsecured
    assign page_nxt = (state_r == bgdbg_pkg::BGDBG_EXEC && hw_ok &&
        cmd == `BGDBG_CMD_WRITE_PORT) ? cmd_data[7:0] : page_r; // [RULE4]
    // ----------------------------------------
    // Action select for the command held in EXEC
    // ----------------------------------------
    wire in_exec = (state_r == bgdbg_pkg::BGDBG_EXEC);
    wire allowed = hw_ok || fw_ok;
    wire do_refuse = in_exec && !allowed; // [RULE10] [RULE11]
    wire do_enter = in_exec && allowed && (cmd == `BGDBG_CMD_BACKGROUND); // [RULE7]
    wire do_exit = in_exec && allowed && (cmd == `BGDBG_CMD_GO); // [RULE9]
    wire do_port_rd = in_exec && allowed && (cmd == `BGDBG_CMD_READ_PORT); // [RULE4]
    wire do_id = in_exec && allowed && id_hit; // [RULE5]
    wire do_mem = in_exec && allowed && (is_hw_mem || is_fw_mem) && !id_hit; // [RULE7] [RULE8]
    wire do_cpu_rd = in_exec && allowed && (cmd == `BGDBG_CMD_READ_CPU); // [RULE9]
    wire do_cpu_wr = in_exec && allowed && (cmd == `BGDBG_CMD_WRITE_CPU); // [RULE9]
    wire do_answer = do_port_rd || do_id || do_cpu_rd;
    wire mem_done = (state_r == bgdbg_pkg::BGDBG_WAIT) && mem_ack_in;
    wire [2:0] cmd_sel = frame[38:36];
    // Address and answer word selection
    wire [ADDR_W-1:0] mem_addr_sel = go_global ? glob_addr : local_addr; // [RULE1] [RULE12]
    assign rsp_nxt = do_port_rd ? {8'h00, page_r} : // [RULE4]
        do_id ? {8'h00, `BGDBG_FAMILY_ID} : // [RULE5]
        do_cpu_rd ? cpu_rdata_in : // [RULE9]
        mem_done ? mem_rdata_in : rsp_r;
    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    // Next state: answers go to SEND, memory work waits for its ack
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bgdbg_pkg::BGDBG_IDLE: begin
                if (frame_valid) begin
                    state_nxt = bgdbg_pkg::BGDBG_EXEC;
                end
            end
            bgdbg_pkg::BGDBG_EXEC: begin
                if (do_answer) begin
                    state_nxt = bgdbg_pkg::BGDBG_SEND;
                end else if (do_mem) begin
                    state_nxt = bgdbg_pkg::BGDBG_WAIT;
                end else begin
                    state_nxt = bgdbg_pkg::BGDBG_IDLE;
                end
            end
            bgdbg_pkg::BGDBG_WAIT: begin
                if (mem_ack_in) begin
                    state_nxt = mem_we_out ? bgdbg_pkg::BGDBG_IDLE : bgdbg_pkg::BGDBG_SEND;
                end
            end
            bgdbg_pkg::BGDBG_SEND: begin
                if (!send_r && !ser_busy) begin
                    state_nxt = bgdbg_pkg::BGDBG_IDLE;
                end
            end
            default: state_nxt = bgdbg_pkg::BGDBG_IDLE;
        endcase
    end
    // Sequencer state and active debug mode flag
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state_r <= bgdbg_pkg::BGDBG_IDLE;
            active_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            active_r <= (active_r || do_enter) && !do_exit; // [RULE7] [RULE9]
        end
    end
    // Answer word and its one-cycle send strobe
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rsp_r <= 16'h0000;
            send_r <= 1'b0;
        end else begin
            rsp_r <= rsp_nxt;
            send_r <= do_answer || (mem_done && !mem_we_out);
        end
    end
    // Memory request, held until the memory acknowledges
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_global_out <= 1'b0;
            mem_addr_out <= '0;
            mem_wdata_out <= 16'h0000;
        end else if (do_mem) begin
            mem_req_out <= 1'b1; // [RULE7] [RULE8]
            mem_we_out <= is_wr;
            mem_global_out <= go_global; // [RULE1] [RULE2]
            mem_addr_out <= mem_addr_sel; // [RULE3]
            mem_wdata_out <= cmd_data;
        end else if (mem_done) begin
            mem_req_out <= 1'b0;
        end
    end
    // CPU register select, direction and write pulse
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            cpu_req_out <= 1'b0;
            cpu_we_out <= 1'b0;
            cpu_sel_out <= 3'h0;
            cpu_wdata_out <= 16'h0000;
        end else begin
            cpu_req_out <= do_cpu_wr; // [RULE9]
            if (do_cpu_wr || do_cpu_rd) begin
                cpu_we_out <= do_cpu_wr;
                cpu_sel_out <= cmd_sel;
            end
            if (do_cpu_wr) begin
                cpu_wdata_out <= cmd_data;
            end
        end
    end
    // Page register and refusal pulse
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            page_r <= `BGDBG_PAGE_RESET;
            refused_out <= 1'b0;
        end else begin
            page_r <= page_nxt; // [RULE4]
            refused_out <= do_refuse; // [RULE10] [RULE11]
        end
    end
    // Registered wire drive and halt level
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            bkgd_out <= 1'b1;
            bkgd_oe_out <= 1'b0;
            cpu_halt_out <= 1'b0;
        end else begin
            bkgd_out <= ser_out;
            bkgd_oe_out <= ser_oe;
            cpu_halt_out <= active_r;
        end
    end
endmodule

// [bgdbg_port_bench.sv]
// Self-checking bench for the background debug command port
`include "bgdbg_defines.svh"
module bgdbg_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MEM_DATA = 16'h6b2d;
    localparam logic [15:0] CPU_DATA = 16'h3c3c;
    logic clk_sys_in, rst_b_in, secure_in, bkgd_in, bkgd_out, bkgd_oe_out, pull_low;
    logic mem_req_out, mem_we_out, mem_global_out, cpu_halt_out, cpu_req_out, cpu_we_out;
    logic refused_out;
    logic mem_ack_in = 1'b0;
    logic [22:0] mem_addr_out;
    logic [15:0] mem_wdata_out, cpu_wdata_out, w;
    logic [2:0] cpu_sel_out;
    logic [40:0] m_rec;
    logic [19:0] c_rec;
    logic [3:0] hw [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
    logic [3:0] fw [5] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
    int errors, total_checks, ref_cnt, mreq_cnt, creq_cnt, mwait;
    // Pulled-up wire: low when either side drives low
    assign bkgd_in = !pull_low && !(bkgd_oe_out && !bkgd_out);
    bgdbg_port bgdbg_port_inst (.clk_sys_in, .rst_b_in, .secure_in, .bkgd_in, .bkgd_out,
        .bkgd_oe_out, .mem_req_out, .mem_we_out, .mem_global_out, .mem_addr_out,
        .mem_wdata_out, .mem_ack_in, .mem_rdata_in(MEM_DATA), .cpu_halt_out, .cpu_req_out,
        .cpu_we_out, .cpu_sel_out, .cpu_wdata_out, .cpu_rdata_in(CPU_DATA), .refused_out);
    bgdbg_host bgdbg_host_inst (.clk_sys_in, .line_in(bkgd_in), .dev_oe_in(bkgd_oe_out),
        .pull_low_out(pull_low));
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Memory stand-in acks in the second cycle of a request; logs requests and pulses
    always @(posedge clk_sys_in) begin
        ref_cnt += (refused_out === 1'b1);
        creq_cnt += (cpu_req_out === 1'b1);
        if (cpu_req_out === 1'b1) c_rec = {cpu_we_out, cpu_sel_out, cpu_wdata_out};
        if (mem_req_out === 1'b1) begin
            m_rec = {mem_global_out, mem_we_out, mem_addr_out, mem_wdata_out};
        end
        #1;
        mwait = (mem_req_out === 1'b1 && !mem_ack_in) ? mwait + 1 : 0;
        mem_ack_in = (mwait == 2);
        mreq_cnt += mem_ack_in;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [43:0] fr(input logic [3:0] c, s, input logic [15:0] a, d);
        return {c, s, 4'h0, a, d};
    endfunction
    task automatic put(input logic [3:0] c, s, input logic [15:0] a, d);
        bgdbg_host_inst.send(fr(c, s, a, d));
        repeat (8) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic get(input logic [3:0] c, input logic [15:0] a);
        bgdbg_host_inst.xfer(fr(c, 4'h0, a, 16'h0000), w);
    endtask
    // A refused command pulses refused exactly once
    task automatic refuse(input logic [3:0] c);
        int n;
        n = ref_cnt;
        put(c, 4'h0, 16'h0100, 16'h00ff);
        chk(32'(ref_cnt - n), 32'h1);
    endtask
    task automatic t_secured();
        secure_in = 1'b1;
        foreach (hw[i]) refuse(hw[i]);
        foreach (fw[i]) refuse(fw[i]);
        secure_in = 1'b0;
        chk({cpu_halt_out, 32'(mreq_cnt + creq_cnt)}, 33'h0);
    endtask
    task automatic t_page();
        int n;
        get(4'h4, 16'h0000);
        chk(w[7:0], 8'h00);
        put(4'h5, 4'h0, 16'h0000, 16'h0005);
        put(4'h3, 4'h0, 16'h1234, 16'ha55a);
        chk(m_rec, {2'b01, 7'h00, 16'h1234, 16'ha55a});
        put(4'h5, 4'h0, 16'h0000, 16'h0085);
        get(4'h2, 16'habcd);
        chk({m_rec[40:16], w}, {2'b10, 7'h05, 16'habcd, MEM_DATA});
        n = mreq_cnt;
        get(4'h4, 16'h0000);
        chk({w[7:0], 32'(mreq_cnt - n)}, {8'h85, 32'h0});
        put(4'h5, 4'h0, 16'h0000, 16'h00ff);
        get(4'h2, 16'hff0f);
        chk({w[7:0], 32'(mreq_cnt - n)}, {`BGDBG_FAMILY_ID, 32'h0});
        put(4'h5, 4'h0, 16'h0000, 16'h0000);
    endtask
    task automatic t_debug();
        put(4'h1, 4'h0, 16'h0000, 16'h0000);
        chk(cpu_halt_out, 1'b1);
        for (int s = 0; s < 5; s++) begin
            put(4'h9, 4'(s), 16'h0000, 16'h1100 + 16'(s));
            chk(c_rec, {1'b1, 3'(s), 16'h1100 + 16'(s)});
        end
        get(4'h8, 16'h0000);
        chk(w, CPU_DATA);
        get(4'hb, 16'h0042);
        chk({w, m_rec[40:16]}, {MEM_DATA, 2'b00, 7'h00, 16'h0042});
        put(4'ha, 4'h0, 16'h0000, 16'h0000);
        chk(cpu_halt_out, 1'b0);
    endtask
    initial begin
        #1000000;
        errors++;
        summarize();
    end
    initial begin
        rst_b_in = 1'b0;
        secure_in = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #1 rst_b_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        t_secured();
        foreach (fw[i]) refuse(fw[i]);
        t_page();
        t_debug();
        foreach (fw[i]) refuse(fw[i]);
        summarize();
    end
endmodule

// [bgdbg_serial.sv]
// Single-wire shifter: receives command frames and sends answers
`include "bgdbg_defines.svh"
module bgdbg_serial (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic wire_in, // Level seen on the debug wire
    input wire logic send_in, // Pulse: start sending answer
    input wire logic [15:0] send_data_in, // Answer word
    output logic wire_out, // Level driven onto the wire
    output logic wire_oe_out, // High while driving the wire
    output logic frame_valid_out, // Pulse: full frame received
    output logic [43:0] frame_out, // Received frame, first bit in msb
    output logic busy_out // Answer in progress
);
    logic [7:0] tick_r;
    logic [5:0] cnt_r;
    logic [43:0] shift_r;
    logic [15:0] tx_r;
    logic tx_on_r;
    logic wire_d_r;
    logic rx_act_r;
    // ----------------------------------------
    // Bit timing: a low start edge opens each bit, sampled mid-cell
    // ----------------------------------------
    wire fall = wire_d_r & ~wire_in & ~tx_on_r;
    wire mid = rx_act_r & (tick_r == (`BGDBG_BIT_CYCLES >> 1));
    wire tx_end = tx_on_r & (tick_r == `BGDBG_BIT_CYCLES - 8'd1);
    // Receiver and transmitter state
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            tick_r <= 8'h00;
            cnt_r <= 6'h00;
            shift_r <= 44'h0;
            tx_r <= 16'h0000;
            tx_on_r <= 1'b0;
            wire_d_r <= 1'b1;
            rx_act_r <= 1'b0;
            frame_valid_out <= 1'b0;
            frame_out <= 44'h0;
        end else begin
            wire_d_r <= wire_in;
            frame_valid_out <= 1'b0;
            if (send_in && !tx_on_r) begin
                tx_r <= send_data_in;
                tx_on_r <= 1'b1;
                tick_r <= 8'h00;
                cnt_r <= 6'h00;
            end else if (tx_on_r) begin
                tick_r <= tx_end ? 8'h00 : tick_r + 8'h01;
                if (tx_end) begin
                    tx_r <= {tx_r[14:0], 1'b0};
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'(`BGDBG_RSP_BITS - 1)) begin
                        tx_on_r <= 1'b0;
                        cnt_r <= 6'h00;
                    end
                end
            end else if (fall) begin
                rx_act_r <= 1'b1;
                tick_r <= 8'h00;
            end else if (rx_act_r) begin
                tick_r <= tick_r + 8'h01;
                if (mid) begin
                    rx_act_r <= 1'b0;
                    shift_r <= {shift_r[42:0], wire_in};
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'(`BGDBG_CMD_BITS - 1)) begin
                        frame_valid_out <= 1'b1;
                        frame_out <= {shift_r[42:0], wire_in};
                        cnt_r <= 6'h00;
                    end
                end
            end
        end
    end
    // Drive: low for a quarter cell, then data, while answering
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            wire_out <= 1'b1;
            wire_oe_out <= 1'b0;
        end else begin
            wire_oe_out <= tx_on_r;
            wire_out <= (tick_r < (`BGDBG_BIT_CYCLES >> 2)) ? 1'b0 : tx_r[15];
        end
    end
    assign busy_out = tx_on_r;
endmodule

// [bgdbg_sva.sv]
// Checker for the background debug command port
module bgdbg_sva (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic secure_in, // Device secured
    input wire logic bkgd_out, // Wire drive level
    input wire logic bkgd_oe_out, // Wire drive enable
    input wire logic mem_req_out, // Memory request
    input wire logic mem_global_out, // Global access
    input wire logic mem_ack_in, // Memory done
    input wire logic cpu_halt_out, // Debug mode
    input wire logic cpu_req_out, // CPU write pulse
    input wire logic refused_out // Refusal pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);
    logic [8:0] oe_cnt_r;
    logic [8:0] oe_cnt_nxt;
    // Counts cycles of unbroken drive
    assign oe_cnt_nxt = bkgd_oe_out ? oe_cnt_r + 9'h001 : 9'h000;
    always_ff @(posedge clk_sys_in) begin
        oe_cnt_r <= rst_b_in ? oe_cnt_nxt : 9'h000;
    end
    property p_ref; refused_out |=> !refused_out; endproperty
    a_ref: assert property (p_ref) else $error("refusal pulse too long");
    property p_cpu; cpu_req_out |=> !cpu_req_out; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu pulse too long");
    property p_fw; cpu_req_out |-> cpu_halt_out && !secure_in; endproperty
    a_fw: assert property (p_fw) else $error("cpu write outside debug");
    property p_sec; $rose(mem_req_out) |-> !secure_in; endproperty
    a_sec: assert property (p_sec) else $error("memory access while secured");
    property p_halt; $rose(cpu_halt_out) |-> !secure_in; endproperty
    a_halt: assert property (p_halt) else $error("debug entered while secured");
    property p_hold; mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_global_out);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
    property p_drop; mem_req_out && mem_ack_in |=> !mem_req_out; endproperty
    a_drop: assert property (p_drop) else $error("request kept after ack");
    property p_lead; $rose(bkgd_oe_out) |-> !bkgd_out [*4]; endproperty
    a_lead: assert property (p_lead) else $error("cell does not start low");
    property p_len; $fell(bkgd_oe_out) |-> oe_cnt_r == 9'h100; endproperty
    a_len: assert property (p_len) else $error("answer length wrong");
    c_glob: cover property (mem_req_out && mem_global_out);
    c_ref: cover property (refused_out);
    c_cpu: cover property (cpu_req_out);
endmodule
bind bgdbg_port bgdbg_sva bgdbg_sva_inst (.clk_sys_in, .rst_b_in, .secure_in, .bkgd_out,
    .bkgd_oe_out, .mem_req_out, .mem_global_out, .mem_ack_in, .cpu_halt_out,
    .cpu_req_out, .refused_out);
